//--- alc_link_control.sv
// register bank for dither, sample marker and serial link control
//
// Notes on behaviour
// - dither rounding bit 2: 0 error into snr, 1 into dc and spurs.
// - dither amplitude bit 1: 0 small dither after reset, 1 large.
// - dither enable bit 0 turns dither on; off after reset.
// - marker bit set: timestamp rides in each output sample lsb.
// - wider link sample: marker takes link lsb, converter lsb kept.
// - lane alignment sequence always reports control bits as zero.
// - link enable 0 holds link reset, serializers down, clocks gated; 1 after reset.
// - link enable 0 holds multiframe counter in reset; sysref ignored.
// - six-bit link mode selector in bits 5:0, reset zero.
// - multiframe length register holds frames minus one, reset 0x1f.
// - 64b/66b modes ignore the register; frames are 256*E/F.
`timescale 1ns/10ps
module alc_link_control #(
	parameter int ADC_WIDTH  = 12,
	parameter int LINK_WIDTH = 16
) (
	input  wire logic                         CLK,
	input  wire logic                         RESET,
	input  wire logic [alc_pkg::ADDR_W-1:0]   ADDR,
	input  wire logic [alc_pkg::DATA_W-1:0]   WDATA,
	input  wire logic                         WR,
	input  wire logic                         RD,
	output logic      [alc_pkg::DATA_W-1:0]   RDATA,
	input  wire logic                         MODE_IS_64B66B,
	input  wire logic [7:0]                   MODE_E,
	input  wire logic [7:0]                   MODE_F,
	input  wire logic                         FRAME_TICK,
	input  wire logic                         SYSREF_PULSE,
	input  wire logic                         SAMPLE_VALID,
	input  wire logic [ADC_WIDTH-1:0]         SAMPLE_IN,
	input  wire logic                         TIMESTAMP_IN,
	output logic                              DITHER_ON,
	output logic                              DITHER_AMPLITUDE_SELECT,
	output logic                              DITHER_ROUNDING_SELECT,
	output logic                              MARKER_INSERT_ON,
	output logic                              SERIAL_LINK_ENABLE,
	output logic      [alc_pkg::MODE_W-1:0]   LINK_MODE_SELECTOR,
	output logic      [7:0]                   FRAMES_PER_MULTIFRAME_MINUS_ONE,
	output logic                              LINK_RESET,
	output logic                              SERDES_POWER_DOWN,
	output logic                              LINK_CLOCK_ON,
	output logic      [alc_pkg::K_W-1:0]      K_EFFECTIVE,
	output logic      [alc_pkg::K_W-1:0]      MULTIFRAME_COUNT,
	output logic                              MULTIFRAME_START,
	output logic      [3:0]                   ILA_CONTROL_BITS,
	output logic                              LINK_SAMPLE_VALID,
	output logic      [LINK_WIDTH-1:0]        LINK_SAMPLE
);

	logic [alc_pkg::DATA_W-1:0] dither_reg;
	logic [alc_pkg::DATA_W-1:0] marker_reg;
	logic [alc_pkg::DATA_W-1:0] link_en_reg;
	logic [alc_pkg::DATA_W-1:0] mode_reg;
	logic [alc_pkg::DATA_W-1:0] mf_len_reg;
	logic [alc_pkg::K_W-1:0]    k_eff;
	logic [alc_pkg::K_W-1:0]    mf_count;
	logic                       mf_start;
	logic                       link_reset;
	logic                       link_en;
	logic [alc_pkg::K_W-1:0]    next_k;

	// frames per multiframe for 64b/66b modes; a zero F is treated as one
	function automatic logic [alc_pkg::K_W-1:0] block_k(input logic [7:0] e, input logic [7:0] f);
		logic [alc_pkg::K_W-1:0] num;
		num = alc_pkg::K_BLOCK_SCALE * {8'h00, e};
		if (f == 8'h00) begin
			block_k = num;
		end else begin
			block_k = num / {8'h00, f};
		end
	endfunction

	assign link_en = link_en_reg[alc_pkg::BIT_LINK_ENABLE];

	// register writes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			dither_reg  <= alc_pkg::RST_DITHER_CONTROL;
			marker_reg  <= alc_pkg::RST_SAMPLE_MARKER;
			link_en_reg <= alc_pkg::RST_LINK_ENABLE;
			mode_reg    <= alc_pkg::RST_LINK_MODE;
			mf_len_reg  <= alc_pkg::RST_MULTIFRAME_LENGTH;
		end else if (WR) begin
			if (ADDR == alc_pkg::OFS_DITHER_CONTROL) begin
				dither_reg <= WDATA;
			end else if (ADDR == alc_pkg::OFS_SAMPLE_MARKER) begin
				marker_reg <= WDATA;
			end else if (ADDR == alc_pkg::OFS_LINK_ENABLE) begin
				link_en_reg <= WDATA;
			end else if (ADDR == alc_pkg::OFS_LINK_MODE) begin
				mode_reg <= WDATA;
			end else if (ADDR == alc_pkg::OFS_MULTIFRAME_LENGTH) begin
				mf_len_reg <= WDATA;
			end
		end
	end

	// read data stands in the cycle after the strobe only; unmapped reads give zero
	always_ff @(posedge CLK) begin
		if (RESET) begin
			RDATA <= '0;
		end else if (RD) begin
			if (ADDR == alc_pkg::OFS_DITHER_CONTROL) begin
				RDATA <= dither_reg;
			end else if (ADDR == alc_pkg::OFS_SAMPLE_MARKER) begin
				RDATA <= marker_reg;
			end else if (ADDR == alc_pkg::OFS_LINK_ENABLE) begin
				RDATA <= link_en_reg;
			end else if (ADDR == alc_pkg::OFS_LINK_MODE) begin
				RDATA <= mode_reg;
			end else if (ADDR == alc_pkg::OFS_MULTIFRAME_LENGTH) begin
				RDATA <= mf_len_reg;
			end else begin
				RDATA <= '0;
			end
		end else begin
			RDATA <= '0;
		end
	end

	// converter controls
	always_ff @(posedge CLK) begin
		if (RESET) begin
			DITHER_ON               <= 1'b0;
			DITHER_AMPLITUDE_SELECT <= 1'b0;
			DITHER_ROUNDING_SELECT  <= 1'b0;
			MARKER_INSERT_ON        <= 1'b0;
			LINK_MODE_SELECTOR      <= '0;
			FRAMES_PER_MULTIFRAME_MINUS_ONE <= alc_pkg::RST_MULTIFRAME_LENGTH;
		end else begin
			DITHER_ON               <= dither_reg[alc_pkg::BIT_DITHER_ON];
			DITHER_AMPLITUDE_SELECT <= dither_reg[alc_pkg::BIT_DITHER_AMP];
			DITHER_ROUNDING_SELECT  <= dither_reg[alc_pkg::BIT_DITHER_ROUNDING];
			MARKER_INSERT_ON        <= marker_reg[alc_pkg::BIT_MARKER_INSERT];
			LINK_MODE_SELECTOR      <= mode_reg[alc_pkg::MODE_W-1:0];
			FRAMES_PER_MULTIFRAME_MINUS_ONE <= mf_len_reg;
		end
	end

	// link power and reset; the link is held while the device is in reset
	always_ff @(posedge CLK) begin
		if (RESET) begin
			SERIAL_LINK_ENABLE <= 1'b0;
			link_reset         <= 1'b1;
			SERDES_POWER_DOWN  <= 1'b1;
			LINK_CLOCK_ON      <= 1'b0;
		end else begin
			SERIAL_LINK_ENABLE <= link_en;
			link_reset         <= ~link_en;
			SERDES_POWER_DOWN  <= ~link_en;
			LINK_CLOCK_ON      <= link_en;
		end
	end

	assign LINK_RESET = link_reset;

	// effective frames per multiframe
	always_comb begin
		if (MODE_IS_64B66B) begin
			next_k = block_k(MODE_E, MODE_F);
		end else begin
			next_k = {8'h00, mf_len_reg} + 16'h0001;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			k_eff <= {8'h00, alc_pkg::RST_MULTIFRAME_LENGTH} + 16'h0001;
		end else begin
			k_eff <= next_k;
		end
	end

	// multiframe counter: held at zero and deaf to sysref while the link is off
	always_ff @(posedge CLK) begin
		if (RESET || !link_en) begin
			mf_count <= '0;
			mf_start <= 1'b0;
		end else if (SYSREF_PULSE) begin
			mf_count <= '0;
			mf_start <= 1'b1;
		end else if (FRAME_TICK) begin
			if (mf_count + 16'h0001 >= k_eff) begin
				mf_count <= '0;
				mf_start <= 1'b1;
			end else begin
				mf_count <= mf_count + 16'h0001;
				mf_start <= 1'b0;
			end
		end else begin
			mf_start <= 1'b0;
		end
	end

	assign K_EFFECTIVE      = k_eff;
	assign MULTIFRAME_COUNT = mf_count;
	assign MULTIFRAME_START = mf_start;

	// the marker bit is never advertised during lane alignment
	always_ff @(posedge CLK) begin
		ILA_CONTROL_BITS <= alc_pkg::ILA_CONTROL_BITS;
	end

	alc_marker_insert #(
		.ADC_WIDTH  (ADC_WIDTH),
		.LINK_WIDTH (LINK_WIDTH)
	) u_marker (
		.clk          (CLK),
		.reset        (RESET || link_reset),
		.marker_on    (MARKER_INSERT_ON),
		.sample_valid (SAMPLE_VALID),
		.sample_in    (SAMPLE_IN),
		.timestamp    (TIMESTAMP_IN),
		.out_valid    (LINK_SAMPLE_VALID),
		.out_sample   (LINK_SAMPLE)
	);

	property p_rounding_follows;
		@(posedge CLK) disable iff (RESET)
		(WR && ADDR == alc_pkg::OFS_DITHER_CONTROL) |=> ##1 (DITHER_ROUNDING_SELECT == $past(WDATA[2], 2));
	endproperty
	a_rounding_follows: assert property (p_rounding_follows) else $error("rounding select wrong");

	property p_amp_reset;
		@(posedge CLK) RESET |=> ##1 (!DITHER_AMPLITUDE_SELECT && !DITHER_ON);
	endproperty
	a_amp_reset: assert property (p_amp_reset) else $error("dither not small and off after reset");

	property p_dither_on_follows;
		@(posedge CLK) disable iff (RESET)
		(WR && ADDR == alc_pkg::OFS_DITHER_CONTROL) |=> ##1 (DITHER_ON == $past(WDATA[0], 2));
	endproperty
	a_dither_on_follows: assert property (p_dither_on_follows) else $error("dither enable wrong");

	property p_cs_zero;
		@(posedge CLK) disable iff (RESET) ##1 ILA_CONTROL_BITS == 4'h0;
	endproperty
	a_cs_zero: assert property (p_cs_zero) else $error("control bits advertised");

	property p_link_off;
		@(posedge CLK) disable iff (RESET)
		!link_en |=> (LINK_RESET && SERDES_POWER_DOWN && !LINK_CLOCK_ON);
	endproperty
	a_link_off: assert property (p_link_off) else $error("link not held off");

	property p_link_default_on;
		@(posedge CLK) RESET ##1 !RESET |=> (SERIAL_LINK_ENABLE && !LINK_RESET);
	endproperty
	a_link_default_on: assert property (p_link_default_on) else $error("link not enabled after reset");

	property p_counter_held;
		@(posedge CLK) disable iff (RESET)
		(!link_en && SYSREF_PULSE) |=> (mf_count == '0 && !mf_start);
	endproperty
	a_counter_held: assert property (p_counter_held) else $error("sysref moved held counter");

	property p_mode_reset;
		@(posedge CLK) RESET |=> (mode_reg == 8'h00 && mf_len_reg == 8'h1f);
	endproperty
	a_mode_reset: assert property (p_mode_reset) else $error("mode or length reset value wrong");

	property p_k_block;
		@(posedge CLK) disable iff (RESET)
		(MODE_IS_64B66B && MODE_F != 8'h00 && $stable(MODE_E) && $stable(MODE_F))
			|=> (K_EFFECTIVE == 16'((16'h0100 * $past(MODE_E)) / $past(MODE_F)));
	endproperty
	a_k_block: assert property (p_k_block) else $error("block mode k wrong");

	property p_k_frame;
		@(posedge CLK) disable iff (RESET)
		(!MODE_IS_64B66B && !WR) |=> (K_EFFECTIVE == {8'h00, mf_len_reg} + 16'h0001);
	endproperty
	a_k_frame: assert property (p_k_frame) else $error("frame mode k wrong");

	property p_readback;
		@(posedge CLK) disable iff (RESET)
		(WR && ADDR == alc_pkg::OFS_MULTIFRAME_LENGTH) ##1 (RD && ADDR == alc_pkg::OFS_MULTIFRAME_LENGTH)
			|=> (RDATA == $past(WDATA, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	// read data must not linger past its one cycle
	property p_rdata_idle;
		@(posedge CLK) disable iff (RESET)
		!RD |=> (RDATA == '0);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

	c_link_disable: cover property (@(posedge CLK) disable iff (RESET) $fell(SERIAL_LINK_ENABLE));
	c_mf_wrap: cover property (@(posedge CLK) disable iff (RESET) FRAME_TICK && mf_start);
	c_sysref_align: cover property (@(posedge CLK) disable iff (RESET) link_en && SYSREF_PULSE);
	c_block_mode: cover property (@(posedge CLK) disable iff (RESET) MODE_IS_64B66B && link_en);

endmodule

//--- alc_link_control_bench.sv
// self-checking bench for the adc link control register bank
`timescale 1ns/10ps
module alc_link_control_bench;
	localparam int AW = 12;
	localparam int LW = 16;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic [11:0]   addr = 12'h000;
	logic [7:0]    wdata = 8'h00;
	logic          wr = 1'b0;
	logic          rd = 1'b0;
	logic          m64 = 1'b0;
	logic [7:0]    me = 8'h01;
	logic [7:0]    mf = 8'h01;
	logic          tick = 1'b0;
	logic          sref = 1'b0;
	logic          sv = 1'b0;
	logic [AW-1:0] sin = 12'h000;
	logic          ts = 1'b0;
	logic [7:0]    rdata, mlen;
	logic          d_on, d_amp, d_rnd, mk_on, l_en, l_rst, pdn, lclk, mf_start, ls_v;
	logic [5:0]    mode;
	logic [15:0]   k_eff, mf_cnt;
	logic [3:0]    ila;
	logic [LW-1:0] ls, rx_last;
	int            rx_cnt;
	int            num_errors = 0;
	int            samples_checked = 0;
	logic [31:0]   lfsr = 32'ha033;
	logic [11:0]   ofs [5] = '{alc_pkg::OFS_DITHER_CONTROL, 12'h160, 12'h200, 12'h201, 12'h202};
	logic [7:0]    rstv [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h1f};
	always #4 clk = ~clk;
	alc_link_control #(.ADC_WIDTH(AW), .LINK_WIDTH(LW)) u_alc_link_control (
		.CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.MODE_IS_64B66B(m64), .MODE_E(me), .MODE_F(mf), .FRAME_TICK(tick), .SYSREF_PULSE(sref),
		.SAMPLE_VALID(sv), .SAMPLE_IN(sin), .TIMESTAMP_IN(ts), .DITHER_ON(d_on),
		.DITHER_AMPLITUDE_SELECT(d_amp), .DITHER_ROUNDING_SELECT(d_rnd), .MARKER_INSERT_ON(mk_on),
		.SERIAL_LINK_ENABLE(l_en), .LINK_MODE_SELECTOR(mode), .FRAMES_PER_MULTIFRAME_MINUS_ONE(mlen),
		.LINK_RESET(l_rst), .SERDES_POWER_DOWN(pdn), .LINK_CLOCK_ON(lclk), .K_EFFECTIVE(k_eff),
		.MULTIFRAME_COUNT(mf_cnt), .MULTIFRAME_START(mf_start), .ILA_CONTROL_BITS(ila),
		.LINK_SAMPLE_VALID(ls_v), .LINK_SAMPLE(ls));
	alc_link_receiver #(.LINK_WIDTH(LW)) u_alc_link_receiver (
		.clk(clk), .reset(rst), .sample_valid(ls_v), .sample(ls), .last_sample(rx_last), .sample_count(rx_cnt));
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [LW-1:0] exp_sample(input logic [AW-1:0] s, input logic t, input logic m);
		logic [LW-1:0] r;
		r = LW'(s) << (LW - AW);
		if (m)
			r[0] = t;
		return r;
	endfunction
	function automatic logic [15:0] exp_k(input logic b, input logic [7:0] e, input logic [7:0] f, input logic [7:0] k);
		if (b)
			return (16'h0100 * {8'h00, e}) / ((f == 8'h00) ? 16'h0001 : {8'h00, f});
		return {8'h00, k} + 16'h0001;
	endfunction
	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		chk_word(n, {8'h00, e}, {8'h00, g});
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		chk_word(n, {15'h0000, e}, {15'h0000, g});
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// write then read the same register with no gap between the strobes
	task automatic wr_rd(input logic [11:0] a, input logic [7:0] d);
		wr_reg(a, d);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg("rdata_back", d, rdata);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_reg("rdata", e, rdata);
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic t, input logic s);
		@(posedge clk);
		tick <= t;
		sref <= s;
		@(posedge clk);
		tick <= 1'b0;
		sref <= 1'b0;
		#1;
	endtask
	task automatic send(input logic [AW-1:0] s, input logic t, input logic m);
		@(posedge clk);
		sv <= 1'b1;
		sin <= s;
		ts <= t;
		@(posedge clk);
		sv <= 1'b0;
		sin <= ~s;
		ts <= ~t;
		#1;
		chk_bit("link_valid", 1'b1, ls_v);
		chk_word("link_sample", exp_sample(s, t, m), ls);
		step();
		chk_word("rx_sample", exp_sample(s, t, m), rx_last);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		results();
	end
	initial begin
		logic [7:0] v;
		logic [7:0] e;
		logic [7:0] f;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step();
		chk_bit("link_enable", 1'b1, l_en);
		for (int i = 0; i < 5; i++)
			rd_chk(ofs[i], rstv[i]);
		step();
		chk_reg("rdata_idle", 8'h00, rdata);
		wr_reg(12'h0fe, 8'h5a);
		rd_chk(12'h0fe, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			v = (i < 2) ? 8'h07 * i[7:0] : lfsr[7:0] & 8'h07;
			wr_reg(ofs[0], v);
			step();
			chk_bit("dither_on", v[0], d_on);
			chk_bit("dither_amp", v[1], d_amp);
			chk_bit("dither_round", v[2], d_rnd);
			rd_chk(ofs[0], v);
		end
		wr_reg(ofs[2], 8'h00);
		step();
		chk_bit("link_reset", 1'b1, l_rst);
		chk_bit("serdes_down", 1'b1, pdn);
		chk_bit("link_clock", 1'b0, lclk);
		chk_bit("link_enable_off", 1'b0, l_en);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk_word("mf_count_off", 16'h0000, mf_cnt);
		chk_bit("mf_start_off", 1'b0, mf_start);
		lfsr = lfsr_next(lfsr);
		v = lfsr[7:0] & 8'h3f;
		wr_reg(ofs[3], v);
		wr_rd(ofs[4], 8'h01);
		step();
		chk_word("mode", {10'h000, v[5:0]}, {10'h000, mode});
		chk_reg("mlen", 8'h01, mlen);
		chk_word("k_eff", exp_k(1'b0, me, mf, 8'h01), k_eff);
		rd_chk(ofs[3], v);
		for (int i = 0; i < 5; i++) begin
			lfsr = lfsr_next(lfsr);
			e = (i == 0) ? 8'hff : lfsr[7:0];
			f = (i == 1) ? 8'h00 : lfsr[15:8];
			@(posedge clk);
			m64 <= 1'b1;
			me <= e;
			mf <= f;
			step();
			chk_word("k_eff_64", exp_k(1'b1, e, f, 8'h01), k_eff);
		end
		@(posedge clk);
		m64 <= 1'b0;
		step();
		chk_word("k_eff_back", 16'h0002, k_eff);
		wr_reg(ofs[2], 8'h01);
		step();
		chk_bit("link_reset_on", 1'b0, l_rst);
		chk_bit("serdes_up", 1'b0, pdn);
		chk_bit("link_clock_on", 1'b1, lclk);
		pulse(1'b1, 1'b0);
		chk_word("mf_count", 16'h0001, mf_cnt);
		chk_bit("mf_start", 1'b0, mf_start);
		pulse(1'b1, 1'b0);
		chk_word("mf_wrap", 16'h0000, mf_cnt);
		chk_bit("mf_start_wrap", 1'b1, mf_start);
		pulse(1'b1, 1'b0);
		pulse(1'b1, 1'b1);
		chk_word("mf_sysref", 16'h0000, mf_cnt);
		chk_bit("mf_start_sysref", 1'b1, mf_start);
		wr_reg(ofs[1], 8'h01);
		step();
		chk_bit("marker_on", 1'b1, mk_on);
		send(12'hfff, 1'b0, 1'b1);
		send(12'h000, 1'b1, 1'b1);
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			send(lfsr[AW-1:0], lfsr[16], 1'b1);
			chk_word("ila_cs", 16'h0000, {12'h000, ila});
		end
		wr_reg(ofs[1], 8'h00);
		step();
		send(12'h555, 1'b1, 1'b0);
		chk_word("rx_count", 16'h0009, rx_cnt[15:0]);
		// second reset in mid-run: every register must fall back to its reset value
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		step();
		chk_bit("link_enable_again", 1'b1, l_en);
		chk_bit("dither_on_reset", 1'b0, d_on);
		chk_bit("dither_amp_reset", 1'b0, d_amp);
		for (int i = 0; i < 5; i++)
			rd_chk(ofs[i], rstv[i]);
		results();
	end
endmodule

//--- alc_link_receiver.sv
// receiving end of the link sample stream, keeps the last sample and a count
`timescale 1ns/10ps
module alc_link_receiver #(
	parameter int LINK_WIDTH = 16
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  sample_valid,
	input  wire logic [LINK_WIDTH-1:0] sample,
	output logic      [LINK_WIDTH-1:0] last_sample,
	output int                         sample_count
);
	always_ff @(posedge clk) begin
		if (reset) begin
			last_sample <= '0;
			sample_count <= 0;
		end else if (sample_valid) begin
			last_sample <= sample;
			sample_count <= sample_count + 1;
		end
	end
endmodule

//--- alc_marker_insert.sv
// places the timestamp marker in the lsb of each outgoing link sample
`timescale 1ns/10ps
module alc_marker_insert #(
	parameter int ADC_WIDTH  = 12,
	parameter int LINK_WIDTH = 16
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  marker_on,
	input  wire logic                  sample_valid,
	input  wire logic [ADC_WIDTH-1:0]  sample_in,
	input  wire logic                  timestamp,
	output logic                       out_valid,
	output logic      [LINK_WIDTH-1:0] out_sample
);

	logic [LINK_WIDTH-1:0] next_sample;

	always_comb begin
		next_sample = '0;
		next_sample[LINK_WIDTH-1 -: ADC_WIDTH] = sample_in;
		if (marker_on) begin
			next_sample[0] = timestamp;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			out_valid  <= 1'b0;
			out_sample <= '0;
		end else begin
			out_valid <= sample_valid;
			if (sample_valid) begin
				out_sample <= next_sample;
			end
		end
	end

	property p_marker_lsb;
		@(posedge clk) disable iff (reset)
		(marker_on && sample_valid) |=> (out_sample[0] == $past(timestamp) && out_valid);
	endproperty
	a_marker_lsb: assert property (p_marker_lsb) else $error("marker not in sample lsb");

	property p_adc_bits_kept;
		@(posedge clk) disable iff (reset)
		sample_valid |=> out_sample[LINK_WIDTH-1 -: ADC_WIDTH] ==
			(LINK_WIDTH > ADC_WIDTH ? $past(sample_in)
			: {$past(sample_in[ADC_WIDTH-1:1]), (marker_on ? out_sample[0] : $past(sample_in[0]))});
	endproperty
	a_adc_bits_kept: assert property (p_adc_bits_kept) else $error("converter bits altered");

	c_marker_sample: cover property (@(posedge clk) disable iff (reset) marker_on && sample_valid && timestamp);

endmodule

//--- alc_pkg.sv
// constants shared by the adc link control register bank
package alc_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	localparam logic [ADDR_W-1:0] OFS_DITHER_CONTROL    = 12'h09d;
	localparam logic [ADDR_W-1:0] OFS_SAMPLE_MARKER     = 12'h160;
	localparam logic [ADDR_W-1:0] OFS_LINK_ENABLE       = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_LINK_MODE         = 12'h201;
	localparam logic [ADDR_W-1:0] OFS_MULTIFRAME_LENGTH = 12'h202;

	localparam logic [DATA_W-1:0] RST_DITHER_CONTROL    = 8'h00;
	localparam logic [DATA_W-1:0] RST_SAMPLE_MARKER     = 8'h00;
	localparam logic [DATA_W-1:0] RST_LINK_ENABLE       = 8'h01;
	localparam logic [DATA_W-1:0] RST_LINK_MODE         = 8'h00;
	localparam logic [DATA_W-1:0] RST_MULTIFRAME_LENGTH = 8'h1f;

	localparam int BIT_DITHER_ON       = 0;
	localparam int BIT_DITHER_AMP      = 1;
	localparam int BIT_DITHER_ROUNDING = 2;
	localparam int BIT_MARKER_INSERT   = 0;
	localparam int BIT_LINK_ENABLE     = 0;
	localparam int MODE_W              = 6;

	localparam int K_W = 16;
	localparam logic [K_W-1:0] K_BLOCK_SCALE = 16'h0100;
	localparam logic [3:0]     ILA_CONTROL_BITS = 4'h0;

endpackage
